// *** verilog/tla_pkg.sv ***
package tla_pkg;

    // ========================================
    // Widths
    localparam int TLA_DATA_W = 16;
    localparam int TLA_CMD_W = 8;
    localparam int TLA_NUM_LIMITS = 7;
    localparam int TLA_CELLS_W = 2;

    // ========================================
    // Device command codes
    localparam logic [7:0] TLA_CMD_BAT_LO = 8'h01;
    localparam logic [7:0] TLA_CMD_BAT_HI = 8'h02;
    localparam logic [7:0] TLA_CMD_VIN_LO = 8'h03;
    localparam logic [7:0] TLA_CMD_VIN_HI = 8'h04;
    localparam logic [7:0] TLA_CMD_RAIL_LO = 8'h05;
    localparam logic [7:0] TLA_CMD_RAIL_HI = 8'h06;
    localparam logic [7:0] TLA_CMD_IIN_HI = 8'h07;
    localparam logic [7:0] TLA_CMD_ENABLE = 8'h0d;
    localparam logic [7:0] TLA_CMD_FLAGS = 8'h0e;
    localparam logic [7:0] TLA_CMD_CELLS = 8'h0f;

    // ========================================
    // Bit positions in enable and flag registers
    localparam int TLA_BIT_BAT_LO = 0;
    localparam int TLA_BIT_BAT_HI = 1;
    localparam int TLA_BIT_VIN_LO = 2;
    localparam int TLA_BIT_VIN_HI = 3;
    localparam int TLA_BIT_RAIL_LO = 4;
    localparam int TLA_BIT_RAIL_HI = 5;
    localparam int TLA_BIT_IIN_HI = 6;

    // ========================================
    // Reset values
    localparam logic [15:0] TLA_LIMIT_RESET = 16'h0000;
    localparam logic [6:0] TLA_ENABLE_RESET = 7'h00;
    localparam logic [6:0] TLA_FLAG_RESET = 7'h00;

    // ========================================
    // Code weights, for software conversion
    localparam real TLA_BAT_UV_PER_LSB = 384.8;
    localparam real TLA_BAT_GROUP_V = 6.0;
    localparam real TLA_VIN_MV_PER_LSB = 1.649;
    localparam real TLA_RAIL_MV_PER_LSB = 1.653;
    localparam real TLA_IIN_UV_PER_LSB = 1.466;

    // ========================================
    // Host controller registers
    localparam int TLA_HOST_ADDR_W = 3;
    localparam logic [2:0] TLA_H_WDATA = 3'h0;
    localparam logic [2:0] TLA_H_CMD = 3'h1;
    localparam logic [2:0] TLA_H_RDATA = 3'h2;
    localparam logic [2:0] TLA_H_STATUS = 3'h3;
    localparam logic [2:0] TLA_H_MASK = 3'h4;
    localparam logic [2:0] TLA_H_LINK = 3'h5;
    localparam int TLA_H_READ_BIT = 8;
    localparam int TLA_EV_W = 3;
    localparam int TLA_EV_READ = 0;
    localparam int TLA_EV_WRITE = 1;
    localparam int TLA_EV_ALERT = 2;
    localparam int TLA_LINK_BUSY = 0;
    localparam int TLA_LINK_ALERT = 1;
    localparam logic [2:0] TLA_EV_RESET = 3'h0;

    typedef enum logic [1:0] {
        TLA_IDLE,
        TLA_WRITE_ISSUE,
        TLA_READ_ISSUE,
        TLA_READ_CAPTURE
    } tla_host_state_t;

endpackage

// *** verilog/tla_link_if.sv ***
`timescale 1ns/1ns
interface tla_link_if;
    import tla_pkg::*;

    logic [TLA_CMD_W-1:0] cmd_code;
    logic [TLA_DATA_W-1:0] wr_data;
    logic wr_strobe;
    logic rd_strobe;
    logic [TLA_DATA_W-1:0] rd_data;
    logic alert_n;

    modport device (
        input cmd_code,
        input wr_data,
        input wr_strobe,
        input rd_strobe,
        output rd_data,
        output alert_n
    );

    modport host (
        output cmd_code,
        output wr_data,
        output wr_strobe,
        output rd_strobe,
        input rd_data,
        input alert_n
    );
endinterface

// *** verilog/tla_device.sv ***
// Functional notes
// R1: Battery low flag when enabled reading below limit
// R2: Battery high flag when enabled reading above limit
// R3: Battery limit compared in raw per-group codes
// R4: Input low flag when enabled reading below limit
// R5: Input high flag when enabled reading above limit
// R6: Input voltage limit in raw input codes
// R7: Rail low flag when enabled reading below limit
// R8: Rail high flag when enabled reading above limit
// R9: Rail limit compared directly in raw codes
// R10: Current high flag when enabled reading above limit
// R11: Current limit in raw sense codes
// R12: Flags readable, cleared only by host write
// R13: Limits are 16-bit signed, reset zero
// R14: Enabled raised flag drives alert line low
// R15: Compare once per conversion; flags stay latched
`timescale 1ns/1ns
module tla_device
    import tla_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register link
    tla_link_if.device link,
    // Telemetry readings and conversion strobes
    input wire logic [TLA_DATA_W-1:0] battery_voltage,
    input wire logic battery_voltage_done,
    input wire logic [TLA_DATA_W-1:0] input_voltage,
    input wire logic input_voltage_done,
    input wire logic [TLA_DATA_W-1:0] output_rail_voltage,
    input wire logic output_rail_voltage_done,
    input wire logic [TLA_DATA_W-1:0] input_current,
    input wire logic input_current_done,
    // Strap pins
    input wire logic [TLA_CELLS_W-1:0] cell_count_select_pins,
    // Alert state
    output logic [TLA_NUM_LIMITS-1:0] limit_flags
);

    // ========================================
    // Helpers
    function automatic logic is_limit_cmd(input logic [7:0] cmd);
        return (cmd >= TLA_CMD_BAT_LO) && (cmd <= TLA_CMD_IIN_HI);
    endfunction

    function automatic logic [2:0] limit_index(input logic [7:0] cmd);
        logic [7:0] offs;
        offs = cmd - TLA_CMD_BAT_LO;
        return offs[2:0];
    endfunction

    // Signed compares; a reading equal to its limit never trips
    function automatic logic below(
        input logic [15:0] reading,
        input logic [15:0] limit
    );
        return $signed(reading) < $signed(limit);
    endfunction

    function automatic logic above(
        input logic [15:0] reading,
        input logic [15:0] limit
    );
        return $signed(reading) > $signed(limit);
    endfunction

    // ========================================
    // State
    logic [TLA_DATA_W-1:0] limit_reg [TLA_NUM_LIMITS];
    logic [TLA_NUM_LIMITS-1:0] enable_reg;
    logic [TLA_NUM_LIMITS-1:0] flag_reg;
    logic [TLA_NUM_LIMITS-1:0] flag_next;
    logic [TLA_NUM_LIMITS-1:0] hit;
    logic [TLA_NUM_LIMITS-1:0] clear;
    logic [TLA_DATA_W-1:0] rd_value;
    logic limit_wr;
    logic enable_wr;
    logic flag_wr;

    assign limit_flags = flag_reg;

    // ========================================
    // Write decode
    // Unmapped codes and the read-only cell code fall through
    always_comb begin
        limit_wr = 1'b0;
        enable_wr = 1'b0;
        flag_wr = 1'b0;
        if (!link.wr_strobe) begin
            limit_wr = 1'b0;
        end else if (is_limit_cmd(link.cmd_code)) begin
            limit_wr = 1'b1;
        end else if (link.cmd_code == TLA_CMD_ENABLE) begin
            enable_wr = 1'b1;
        end else if (link.cmd_code == TLA_CMD_FLAGS) begin
            flag_wr = 1'b1;
        end
    end

    // ========================================
    // Limit registers
    // Raw two's-complement codes, no scaling applied
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < TLA_NUM_LIMITS; i++) begin
                limit_reg[i] <= TLA_LIMIT_RESET; // [R13]
            end
        end else if (limit_wr) begin
            limit_reg[limit_index(link.cmd_code)] <= link.wr_data; // [R13]
        end
    end

    // ========================================
    // Enable register
    // Bit order follows the limit command order
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            enable_reg <= TLA_ENABLE_RESET;
        end else if (enable_wr) begin
            enable_reg <= link.wr_data[TLA_NUM_LIMITS-1:0];
        end
    end

    // ========================================
    // Threshold comparisons, raw codes against raw codes
    // Done strobe gates each compare: one look per conversion
    always_comb begin
        hit = '0;
        hit[TLA_BIT_BAT_LO] = battery_voltage_done
            && enable_reg[TLA_BIT_BAT_LO]
            && below(battery_voltage, limit_reg[TLA_BIT_BAT_LO]); // [R1] [R3]
        hit[TLA_BIT_BAT_HI] = battery_voltage_done
            && enable_reg[TLA_BIT_BAT_HI]
            && above(battery_voltage, limit_reg[TLA_BIT_BAT_HI]); // [R2] [R3]
        hit[TLA_BIT_VIN_LO] = input_voltage_done
            && enable_reg[TLA_BIT_VIN_LO]
            && below(input_voltage, limit_reg[TLA_BIT_VIN_LO]); // [R4] [R6]
        hit[TLA_BIT_VIN_HI] = input_voltage_done
            && enable_reg[TLA_BIT_VIN_HI]
            && above(input_voltage, limit_reg[TLA_BIT_VIN_HI]); // [R5] [R6]
        hit[TLA_BIT_RAIL_LO] = output_rail_voltage_done
            && enable_reg[TLA_BIT_RAIL_LO]
            && below(output_rail_voltage,
                     limit_reg[TLA_BIT_RAIL_LO]); // [R7] [R9]
        hit[TLA_BIT_RAIL_HI] = output_rail_voltage_done
            && enable_reg[TLA_BIT_RAIL_HI]
            && above(output_rail_voltage,
                     limit_reg[TLA_BIT_RAIL_HI]); // [R8] [R9]
        hit[TLA_BIT_IIN_HI] = input_current_done
            && enable_reg[TLA_BIT_IIN_HI]
            && above(input_current, limit_reg[TLA_BIT_IIN_HI]); // [R10] [R11]
    end

    // ========================================
    // Alert flags: a zero written clears, a new hit wins
    always_comb begin
        clear = '0;
        if (flag_wr) begin
            clear = ~link.wr_data[TLA_NUM_LIMITS-1:0]; // [R12]
        end
        flag_next = (flag_reg & ~clear) | hit; // [R12] [R15]
    end

    // Flags stay set after the reading returns in range
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flag_reg <= TLA_FLAG_RESET;
        end else begin
            flag_reg <= flag_next; // [R15]
        end
    end

    // ========================================
    // Alert line
    // Built from flag_next so the line drops with the flag
    // Dropping an enable frees the line but keeps the flag
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            link.alert_n <= 1'b1;
        end else begin
            link.alert_n <= ~|(flag_next & enable_reg); // [R14]
        end
    end

    // ========================================
    // Read path
    always_comb begin
        rd_value = '0;
        if (is_limit_cmd(link.cmd_code)) begin
            rd_value = limit_reg[limit_index(link.cmd_code)];
        end else if (link.cmd_code == TLA_CMD_ENABLE) begin
            rd_value = TLA_DATA_W'(enable_reg);
        end else if (link.cmd_code == TLA_CMD_FLAGS) begin
            rd_value = TLA_DATA_W'(flag_reg); // [R12]
        end else if (link.cmd_code == TLA_CMD_CELLS) begin
            rd_value = TLA_DATA_W'(cell_count_select_pins); // [R3]
        end
    end

    // Captured at the strobe edge, held until the next read
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            link.rd_data <= '0;
        end else if (link.rd_strobe) begin
            link.rd_data <= rd_value;
        end
    end

endmodule

// *** verilog/tla_host.sv ***
`timescale 1ns/1ns
module tla_host
    import tla_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Software port
    input wire logic [TLA_HOST_ADDR_W-1:0] sw_addr,
    input wire logic [TLA_DATA_W-1:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [TLA_DATA_W-1:0] sw_rdata,
    output logic irq,
    // Register link
    tla_link_if.host link
);

    // ========================================
    // State
    tla_host_state_t state_reg;
    logic [TLA_DATA_W-1:0] wdata_reg;
    logic [TLA_DATA_W-1:0] rdata_reg;
    logic [TLA_EV_W-1:0] status_reg;
    logic [TLA_EV_W-1:0] mask_reg;
    logic [TLA_EV_W-1:0] event_set;
    logic alert_prev_reg;
    logic start;

    assign start = sw_wr && (sw_addr == TLA_H_CMD) && (state_reg == TLA_IDLE);

    // ========================================
    // Transfer sequencer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= TLA_IDLE;
            link.cmd_code <= '0;
            link.wr_data <= '0;
            link.wr_strobe <= 1'b0;
            link.rd_strobe <= 1'b0;
        end else begin
            link.wr_strobe <= 1'b0;
            link.rd_strobe <= 1'b0;
            case (state_reg)
                TLA_IDLE: begin
                    if (start) begin
                        link.cmd_code <= sw_wdata[TLA_CMD_W-1:0];
                        link.wr_data <= wdata_reg;
                        if (sw_wdata[TLA_H_READ_BIT]) begin
                            link.rd_strobe <= 1'b1;
                            state_reg <= TLA_READ_ISSUE;
                        end else begin
                            link.wr_strobe <= 1'b1; // [R12]
                            state_reg <= TLA_WRITE_ISSUE;
                        end
                    end
                end
                TLA_WRITE_ISSUE: begin
                    state_reg <= TLA_IDLE;
                end
                TLA_READ_ISSUE: begin
                    state_reg <= TLA_READ_CAPTURE;
                end
                default: begin
                    state_reg <= TLA_IDLE;
                end
            endcase
        end
    end

    // ========================================
    // Software registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wdata_reg <= '0;
            mask_reg <= TLA_EV_RESET;
        end else if (sw_wr && sw_addr == TLA_H_WDATA) begin
            wdata_reg <= sw_wdata;
        end else if (sw_wr && sw_addr == TLA_H_MASK) begin
            mask_reg <= sw_wdata[TLA_EV_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg <= '0;
        end else if (state_reg == TLA_READ_CAPTURE) begin
            rdata_reg <= link.rd_data; // [R12]
        end
    end

    // ========================================
    // Events, status and interrupt
    always_comb begin
        event_set = '0;
        event_set[TLA_EV_READ] = state_reg == TLA_READ_CAPTURE;
        event_set[TLA_EV_WRITE] = state_reg == TLA_WRITE_ISSUE;
        event_set[TLA_EV_ALERT] = alert_prev_reg && !link.alert_n; // [R14]
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            alert_prev_reg <= 1'b1;
        end else begin
            alert_prev_reg <= link.alert_n;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            status_reg <= TLA_EV_RESET;
        end else if (sw_wr && sw_addr == TLA_H_STATUS) begin
            status_reg <= (status_reg & ~sw_wdata[TLA_EV_W-1:0]) | event_set;
        end else begin
            status_reg <= status_reg | event_set;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_reg & mask_reg);
        end
    end

    // ========================================
    // Software read data
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sw_rdata <= '0;
        end else if (!sw_rd) begin
            sw_rdata <= '0;
        end else if (sw_addr == TLA_H_WDATA) begin
            sw_rdata <= wdata_reg;
        end else if (sw_addr == TLA_H_RDATA) begin
            sw_rdata <= rdata_reg;
        end else if (sw_addr == TLA_H_STATUS) begin
            sw_rdata <= TLA_DATA_W'(status_reg);
        end else if (sw_addr == TLA_H_MASK) begin
            sw_rdata <= TLA_DATA_W'(mask_reg);
        end else if (sw_addr == TLA_H_LINK) begin
            sw_rdata <= '0;
            sw_rdata[TLA_LINK_BUSY] <= state_reg != TLA_IDLE;
            sw_rdata[TLA_LINK_ALERT] <= !link.alert_n;
        end else begin
            sw_rdata <= '0;
        end
    end

endmodule

// *** verif/tla_monitor.sv ***
`timescale 1ns/1ns
module tla_monitor
    import tla_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Link
    input wire logic [TLA_CMD_W-1:0] cmd_code,
    input wire logic [TLA_DATA_W-1:0] wr_data,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    input wire logic [TLA_DATA_W-1:0] rd_data,
    input wire logic alert_n
);
    logic [15:0] lim_q [8];
    logic [6:0] en_q;
    logic [15:0] exp_q;

    // ========================================
    // Shadow of written limits and enables
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 8; i++) begin
                lim_q[i] <= 16'h0000;
            end
            en_q <= 7'h00;
        end else if (wr_strobe) begin
            if (cmd_code inside {[8'h01:8'h07]}) begin
                lim_q[cmd_code[2:0]] <= wr_data;
            end
            if (cmd_code == 8'h0d) begin
                en_q <= wr_data[6:0];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            exp_q <= 16'h0000;
        end else if (rd_strobe) begin
            exp_q <= (cmd_code == 8'h0d) ? {9'h000, en_q}
                : lim_q[cmd_code[2:0]];
        end
    end

    // ========================================
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_lim_rd;
        rd_strobe && cmd_code inside {[8'h01:8'h07]};
    endsequence
    sequence s_bad_rd;
        rd_strobe && cmd_code inside {8'h00, [8'h08:8'h0c], [8'h10:8'hff]};
    endsequence

    lim_readback_a:
        assert property (s_lim_rd |=> rd_data == exp_q)
        else $error("Limit readback differs");
    en_readback_a:
        assert property (rd_strobe && cmd_code == 8'h0d |=> rd_data == exp_q)
        else $error("Enable readback differs");
    unmapped_zero_a:
        assert property (s_bad_rd |=> rd_data == 16'h0000)
        else $error("Unmapped read not zero");
    flag_upper_a:
        assert property (rd_strobe && cmd_code == 8'h0e |=> rd_data[15:7] == 0)
        else $error("Flag upper bits set");
    rdata_hold_a:
        assert property (!rd_strobe |=> $stable(rd_data))
        else $error("Read data moved without read");
    alert_idle_a:
        assert property (en_q == 7'h00 |=> alert_n)
        else $error("Alert with no enable");
    alert_fall_a:
        assert property ($fell(alert_n) |-> $past(en_q) != 7'h00)
        else $error("Alert fell while disabled");
    strobe_excl_a:
        assert property (!(wr_strobe && rd_strobe))
        else $error("Both strobes high");
    strobe_pulse_a:
        assert property (wr_strobe || rd_strobe |=> !wr_strobe && !rd_strobe)
        else $error("Strobe longer than one cycle");
endmodule

// *** verif/telemetry_limit_alerts_tb.sv ***
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module telemetry_limit_alerts_tb
    import tla_pkg::*;
;
    typedef struct packed {
        logic [2:0] b;
        logic [15:0] lim;
        logic [15:0] rd;
        logic en;
        logic hit;
    } tla_row_t;
    localparam int NR = 11;
    tla_row_t rows [NR] = '{
        '{3'd0, 16'h0064, 16'h0063, 1'b1, 1'b1},
        '{3'd0, 16'h0064, 16'h0064, 1'b1, 1'b0},
        '{3'd1, 16'h0064, 16'h0065, 1'b1, 1'b1},
        '{3'd1, 16'hfff0, 16'h0000, 1'b1, 1'b1},
        '{3'd2, 16'h0010, 16'hfff0, 1'b1, 1'b1},
        '{3'd3, 16'h0010, 16'h0010, 1'b1, 1'b0},
        '{3'd3, 16'h0000, 16'h8000, 1'b1, 1'b0},
        '{3'd4, 16'h8000, 16'h8000, 1'b1, 1'b0},
        '{3'd5, 16'h7ffe, 16'h7fff, 1'b1, 1'b1},
        '{3'd6, 16'h0100, 16'h0101, 1'b1, 1'b1},
        '{3'd6, 16'h0100, 16'h0200, 1'b0, 1'b0}};
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] sw_addr = 3'h0;
    logic [15:0] sw_wdata = 16'h0000;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic [15:0] sw_rdata;
    logic irq;
    logic [15:0] tv [4] = '{default: 16'h0000};
    logic [3:0] tdone = 4'h0;
    logic [1:0] cells = 2'h2;
    logic [6:0] flags;
    logic [15:0] rv;
    tla_row_t r;
    int fails = 0;
    int checked = 0;

    tla_link_if link ();
    tla_device tla_device_inst (.clk(clk), .reset_n(reset_n), .link(link),
        .battery_voltage(tv[0]), .battery_voltage_done(tdone[0]),
        .input_voltage(tv[1]), .input_voltage_done(tdone[1]),
        .output_rail_voltage(tv[2]), .output_rail_voltage_done(tdone[2]),
        .input_current(tv[3]), .input_current_done(tdone[3]),
        .cell_count_select_pins(cells), .limit_flags(flags));
    tla_host tla_host_inst (.clk(clk), .reset_n(reset_n), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata), .irq(irq), .link(link));
    tla_monitor tla_monitor_inst (.clk(clk), .reset_n(reset_n),
        .cmd_code(link.cmd_code), .wr_data(link.wr_data),
        .wr_strobe(link.wr_strobe), .rd_strobe(link.rd_strobe),
        .rd_data(link.rd_data), .alert_n(link.alert_n));

    always #5 clk = ~clk;

    // ========================================
    // Bus tasks
    task sw_w(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge clk);
        sw_wr <= 1'b0;
    endtask
    task sw_r(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clk);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
    endtask
    task dw(input logic [7:0] c, input logic [15:0] d);
        sw_w(TLA_H_WDATA, d);
        sw_w(TLA_H_CMD, {8'h00, c});
        repeat (4) @(posedge clk);
    endtask
    task dr(input logic [7:0] c, output logic [15:0] d);
        sw_w(TLA_H_CMD, {8'h01, c});
        repeat (4) @(posedge clk);
        sw_r(TLA_H_RDATA, d);
    endtask
    task tel(input int q, input logic [15:0] v);
        @(posedge clk);
        tv[q] <= v;
        tdone[q] <= 1'b1;
        @(posedge clk);
        tdone[q] <= 1'b0;
    endtask
    task results;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #300000;
        fails++;
        results();
    end

    // ========================================
    // Tests
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < NR; i++) begin
            r = rows[i];
            dw(TLA_CMD_FLAGS, 16'h0000);
            dw(TLA_CMD_ENABLE, {9'h000, 7'(r.en) << r.b});
            dw(TLA_CMD_BAT_LO + 8'(r.b), r.lim);
            dr(TLA_CMD_BAT_LO + 8'(r.b), rv);
            `CHK(rv, r.lim)
            tel(int'(r.b >> 1), r.rd);
            dr(TLA_CMD_FLAGS, rv);
            `CHK(rv, {9'h000, 7'(r.hit) << r.b})
            `CHK(flags, 7'(r.hit) << r.b)
            `CHK(link.alert_n, !r.hit)
        end
        $display("table done");
        sw_w(TLA_H_MASK, 16'h0004);
        sw_w(TLA_H_STATUS, 16'h0007);
        dw(TLA_CMD_ENABLE, 16'h0001);
        dr(TLA_CMD_ENABLE, rv);
        `CHK(rv, 16'h0001)
        dw(TLA_CMD_BAT_LO, 16'h0100);
        tel(0, 16'h0050);
        tel(0, 16'h0200);
        dw(TLA_CMD_FLAGS, 16'h0001);
        dr(TLA_CMD_FLAGS, rv);
        `CHK(rv, 16'h0001)
        `CHK(irq, 1'b1)
        sw_r(TLA_H_LINK, rv);
        `CHK(rv, 16'h0002)
        sw_w(TLA_H_MASK, 16'h0000);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        sw_r(TLA_H_STATUS, rv);
        `CHK(rv[2:0], 3'h7)
        sw_w(TLA_H_STATUS, 16'h0007);
        sw_r(TLA_H_STATUS, rv);
        `CHK(rv[2:0], 3'h0)
        dw(TLA_CMD_ENABLE, 16'h0000);
        `CHK(link.alert_n, 1'b1)
        `CHK(flags, 7'h01)
        dw(TLA_CMD_FLAGS, 16'h0000);
        dw(TLA_CMD_ENABLE, 16'h0001);
        @(posedge clk);
        tv[0] <= 16'h0010;
        dr(TLA_CMD_FLAGS, rv);
        `CHK(rv, 16'h0000)
        `CHK(link.alert_n, 1'b1)
        sw_r(3'h7, rv);
        `CHK(rv, 16'h0000)
        $display("sticky and interrupt done");
        tel(0, 16'h0010);
        @(posedge clk);
        `CHK(flags, 7'h01)
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(flags, 7'h00)
        `CHK(link.alert_n, 1'b1)
        reset_n <= 1'b1;
        dr(TLA_CMD_BAT_LO, rv);
        `CHK(rv, 16'h0000)
        $display("mid-run reset done");
        for (int c = 1; c < 8; c++) begin
            dr(8'(c), rv);
            `CHK(rv, 16'h0000)
        end
        dr(TLA_CMD_ENABLE, rv);
        `CHK(rv, 16'h0000)
        dr(TLA_CMD_CELLS, rv);
        `CHK(rv, 16'h0002)
        dr(8'h08, rv);
        `CHK(rv, 16'h0000)
        $display("reset values done");
        results();
    end
endmodule
